/* File: src/sgcr_pkg.sv */
package sgcr_pkg;

    // Register access port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_GC_ONE = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_GC_TWO = 8'h04;

    // Field positions, first global control register
    localparam int BIT_PASS_ALL   = 7;
    localparam int BIT_FRAME_2K   = 6;
    localparam int BIT_TX_FC_DIS  = 5;
    localparam int BIT_RX_FC_DIS  = 4;
    localparam int BIT_LEN_CHECK  = 3;
    localparam int BIT_AGING_EN   = 2;
    localparam int BIT_FAST_AGE   = 1;
    localparam int BIT_AGGR_BOFF  = 0;

    // Field positions, second global control register
    localparam int BIT_VLAN_STRICT = 7;
    localparam int BIT_MCAST_EXCL  = 6;

    // Reset values; strapped bits are overlaid at reset
    localparam logic [DATA_W-1:0] GC_ONE_RESET   = 8'h04;
    localparam logic [DATA_W-1:0] GC_TWO_RESET   = 8'hC0;
    localparam logic [DATA_W-1:0] GC_TWO_WR_MASK = 8'hC0;
    localparam logic [DATA_W-1:0] RDATA_NONE     = 8'h00;

    // Frame length figures
    localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05DC; // 1500
    localparam logic [15:0] MAX_LEN_STD    = 16'h05EE; // 1518
    localparam logic [15:0] MAX_LEN_2K     = 16'h0800; // 2048

    // Aging timing
    localparam int AGE_CNT_W = 36;
    localparam longint unsigned CLK_MHZ = 100;
    localparam longint unsigned FAST_AGE_US = 800;
    localparam longint unsigned NORMAL_AGE_S = 300;
    localparam longint unsigned FAST_AGE_CYCLES = FAST_AGE_US * CLK_MHZ;
    localparam longint unsigned NORMAL_AGE_CYCLES =
        NORMAL_AGE_S * CLK_MHZ * 64'h0000_0000_000F_4240;

    // Description of one received frame, presented for a verdict
    typedef struct packed {
        logic [15:0] len_type;     // Length/type field
        logic [15:0] payload_len;  // Bytes actually in the data field
        logic [15:0] frame_len;    // Whole frame length
        logic        rx_error;     // CRC, symbol or alignment fault
        logic        known_unicast;
        logic        crosses_vlan; // Egress outside ingress port VLAN
        logic        da_broadcast; // All-ones destination
        logic        da_multicast; // Group address, not broadcast
    } sgcr_frame_type;

endpackage

/* File: src/sgcr_strap_sync.sv */
`timescale 1ns/10ps

// Three-stage pin sampler; level moves only when stages two and three agree
module sgcr_strap_sync
(
    input  wire logic i_clk,
    input  wire logic i_pin,
    output logic      o_level
);

    logic meta_reg;
    logic mid_reg;
    logic late_reg;
    logic level_reg;

    // Plain shift chain; meta_reg feeds only mid_reg
    always_ff @(posedge i_clk)
    begin
        meta_reg <= i_pin;
        mid_reg  <= meta_reg;
        late_reg <= mid_reg;
    end

    // Agreement filter; not reset so it can follow the pin during reset
    always_ff @(posedge i_clk)
    begin
        if (mid_reg == late_reg)
        begin
            level_reg <= late_reg;
        end
    end

    assign o_level = level_reg;

endmodule

/* File: src/sgcr_top.sv */
`timescale 1ns/10ps

// What this block does
// - Pass-all bit forwards even errored frames
// - Bit six enables 2K-byte frame acceptance
// - Bit five forces transmit pause off
// - Bit four forces receive pause off
// - One strap sets both pause-disable defaults
// - Check length field below 1500, drop mismatch
// - Bit two enables address aging, default on
// - Bit one selects 800us fast aging
// - Bit zero aggressive back-off, strapped default
// - Strict port-VLAN boundary, unicast relaxation
// - Storm protection may exclude multicast frames
module sgcr_top
#(
    parameter logic [35:0] P_FAST_AGE_CYCLES =
        sgcr_pkg::FAST_AGE_CYCLES[35:0],
    parameter logic [35:0] P_NORMAL_AGE_CYCLES =
        sgcr_pkg::NORMAL_AGE_CYCLES[35:0]
)
(
    input  wire logic                        I_MCLK,
    input  wire logic                        I_RST,
    input  wire logic [sgcr_pkg::ADDR_W-1:0] I_REG_ADDR,
    input  wire logic                        I_REG_WR,
    input  wire logic [sgcr_pkg::DATA_W-1:0] I_REG_WDATA,
    input  wire logic                        I_REG_RD,
    output logic      [sgcr_pkg::DATA_W-1:0] O_REG_RDATA,
    output logic                             O_REG_RVALID,
    input  wire logic                        I_FLOW_CONTROL_STRAP_PIN,
    input  wire logic                        I_BACKOFF_STRAP_PIN,
    input  wire logic                        I_AN_TX_PAUSE,
    input  wire logic                        I_AN_RX_PAUSE,
    output logic                             O_TX_FLOW_EN,
    output logic                             O_RX_FLOW_EN,
    output logic                             O_AGGR_BACKOFF_EN,
    output logic                             O_AGE_TICK,
    input  wire logic                        I_FRAME_VALID,
    input  wire sgcr_pkg::sgcr_frame_type    I_FRAME,
    output logic                             O_FRAME_DONE,
    output logic                             O_FRAME_DROP,
    output logic                             O_FRAME_VLAN_BLOCK,
    output logic                             O_STORM_COUNT
);

    logic [sgcr_pkg::DATA_W-1:0]    gc_one_reg;
    logic [sgcr_pkg::DATA_W-1:0]    gc_two_reg;
    logic [sgcr_pkg::DATA_W-1:0]    rdata_reg;
    logic                           rvalid_reg;
    logic                           fc_strap;
    logic                           boff_strap;
    logic                           tx_flow_reg;
    logic                           rx_flow_reg;
    logic                           aggr_boff_reg;
    logic [sgcr_pkg::AGE_CNT_W-1:0] age_cnt_reg;
    logic [sgcr_pkg::AGE_CNT_W-1:0] age_cnt_next;
    logic                           age_tick_reg;
    logic                           fast_prev_reg;
    logic [35:0]                    age_period;
    logic                           done_reg;
    logic                           drop_reg;
    logic                           vlan_block_reg;
    logic                           storm_reg;

    // Length/type field is a length and disagrees with the data field
    function automatic logic len_mismatch(
        input sgcr_pkg::sgcr_frame_type f);
        len_mismatch = (f.len_type < sgcr_pkg::LEN_TYPE_LIMIT) &&
                       (f.len_type != f.payload_len);
    endfunction

    // Counter sits on the last cycle of the aging period
    function automatic logic period_end(
        input logic [sgcr_pkg::AGE_CNT_W-1:0] cnt,
        input logic [35:0]                    period);
        period_end = (cnt >= period - 36'h0_0000_0001);
    endfunction

    // Largest frame the ports accept under the current setting
    function automatic logic [15:0] max_len(input logic allow_2k);
        max_len = allow_2k ? sgcr_pkg::MAX_LEN_2K : sgcr_pkg::MAX_LEN_STD;
    endfunction

    // Strap pin samplers
    sgcr_strap_sync u_fc_strap
    (
        .i_clk   (I_MCLK),
        .i_pin   (I_FLOW_CONTROL_STRAP_PIN),
        .o_level (fc_strap)
    );

    sgcr_strap_sync u_boff_strap
    (
        .i_clk   (I_MCLK),
        .i_pin   (I_BACKOFF_STRAP_PIN),
        .o_level (boff_strap)
    );

    // First control register; straps follow the pin only while in reset
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            gc_one_reg <= sgcr_pkg::GC_ONE_RESET;
            gc_one_reg[sgcr_pkg::BIT_TX_FC_DIS] <= fc_strap;
            gc_one_reg[sgcr_pkg::BIT_RX_FC_DIS] <= fc_strap;
            gc_one_reg[sgcr_pkg::BIT_AGGR_BOFF] <= boff_strap;
        end
        else if (I_REG_WR && (I_REG_ADDR == sgcr_pkg::ADDR_GC_ONE))
        begin
            gc_one_reg <= I_REG_WDATA; // Each bit on its own
        end
    end

    // Second control register; only the top two bits are kept
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            gc_two_reg <= sgcr_pkg::GC_TWO_RESET;
        end
        else if (I_REG_WR && (I_REG_ADDR == sgcr_pkg::ADDR_GC_TWO))
        begin
            gc_two_reg <= I_REG_WDATA & sgcr_pkg::GC_TWO_WR_MASK;
        end
    end

    // Read port; unmapped addresses answer zero
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            rdata_reg  <= sgcr_pkg::RDATA_NONE;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= I_REG_RD;
            if (I_REG_RD)
            begin
                case (I_REG_ADDR)
                    sgcr_pkg::ADDR_GC_ONE: rdata_reg <= gc_one_reg;
                    sgcr_pkg::ADDR_GC_TWO: rdata_reg <= gc_two_reg;
                    default:               rdata_reg <= sgcr_pkg::RDATA_NONE;
                endcase
            end
        end
    end

    // Pause enables: negotiated result unless software forces it off
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            tx_flow_reg   <= 1'b0;
            rx_flow_reg   <= 1'b0;
            aggr_boff_reg <= 1'b0;
        end
        else
        begin
            tx_flow_reg <= I_AN_TX_PAUSE &
                           ~gc_one_reg[sgcr_pkg::BIT_TX_FC_DIS];
            rx_flow_reg <= I_AN_RX_PAUSE &
                           ~gc_one_reg[sgcr_pkg::BIT_RX_FC_DIS];
            aggr_boff_reg <= gc_one_reg[sgcr_pkg::BIT_AGGR_BOFF];
        end
    end

    // Aging period; fast mode shortens it to the fast figure
    assign age_period = gc_one_reg[sgcr_pkg::BIT_FAST_AGE] ?
                        P_FAST_AGE_CYCLES : P_NORMAL_AGE_CYCLES;

    // Counter restarts when aging is off or the period changes
    always_comb
    begin
        age_cnt_next = age_cnt_reg + 36'h0_0000_0001;
        if (!gc_one_reg[sgcr_pkg::BIT_AGING_EN] ||
            (fast_prev_reg != gc_one_reg[sgcr_pkg::BIT_FAST_AGE]) ||
            period_end(age_cnt_reg, age_period))
        begin
            age_cnt_next = 36'h0_0000_0000;
        end
    end

    // Age tick: one pulse per period, none while aging is disabled
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            age_cnt_reg   <= 36'h0_0000_0000;
            age_tick_reg  <= 1'b0;
            fast_prev_reg <= 1'b0;
        end
        else
        begin
            age_cnt_reg   <= age_cnt_next;
            fast_prev_reg <= gc_one_reg[sgcr_pkg::BIT_FAST_AGE];
            age_tick_reg  <= gc_one_reg[sgcr_pkg::BIT_AGING_EN] &&
                (fast_prev_reg == gc_one_reg[sgcr_pkg::BIT_FAST_AGE]) &&
                period_end(age_cnt_reg, age_period);
        end
    end

    // Frame verdict, one cycle after the frame is presented
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            done_reg       <= 1'b0;
            drop_reg       <= 1'b0;
            vlan_block_reg <= 1'b0;
            storm_reg      <= 1'b0;
        end
        else
        begin
            done_reg  <= I_FRAME_VALID;
            drop_reg  <= 1'b0;
            vlan_block_reg <= 1'b0;
            storm_reg <= 1'b0;
            if (I_FRAME_VALID)
            begin
                // Pass-all keeps bad frames for the sniffer port
                drop_reg <= !gc_one_reg[sgcr_pkg::BIT_PASS_ALL] &&
                    (I_FRAME.rx_error ||
                     (I_FRAME.frame_len >
                      max_len(gc_one_reg[sgcr_pkg::BIT_FRAME_2K])) ||
                     (gc_one_reg[sgcr_pkg::BIT_LEN_CHECK] &&
                      len_mismatch(I_FRAME)));
                vlan_block_reg <= I_FRAME.crosses_vlan &&
                    (gc_two_reg[sgcr_pkg::BIT_VLAN_STRICT] ||
                     !I_FRAME.known_unicast);
                storm_reg <= I_FRAME.da_broadcast ||
                    (I_FRAME.da_multicast &&
                     !gc_two_reg[sgcr_pkg::BIT_MCAST_EXCL]);
            end
        end
    end

    // Outputs straight from flip-flops
    assign O_REG_RDATA        = rdata_reg;
    assign O_REG_RVALID       = rvalid_reg;
    assign O_TX_FLOW_EN       = tx_flow_reg;
    assign O_RX_FLOW_EN       = rx_flow_reg;
    assign O_AGGR_BACKOFF_EN  = aggr_boff_reg;
    assign O_AGE_TICK         = age_tick_reg;
    assign O_FRAME_DONE       = done_reg;
    assign O_FRAME_DROP       = drop_reg;
    assign O_FRAME_VLAN_BLOCK = vlan_block_reg;
    assign O_STORM_COUNT      = storm_reg;

endmodule

/* File: tb/sgcr_top_properties.sv */
`timescale 1ns/10ps

// Port relations of the bank; silent while reset is high
module sgcr_top_properties
(
    input wire logic       I_MCLK,
    input wire logic       I_RST,
    input wire logic       I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic       O_REG_RVALID,
    input wire logic       I_AN_TX_PAUSE,
    input wire logic       I_AN_RX_PAUSE,
    input wire logic       O_TX_FLOW_EN,
    input wire logic       O_RX_FLOW_EN,
    input wire logic       I_FRAME_VALID,
    input wire logic       O_FRAME_DONE,
    input wire logic       O_FRAME_DROP,
    input wire logic       O_FRAME_VLAN_BLOCK,
    input wire logic       O_STORM_COUNT
);
    default clocking dc @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    // Read answers: one pulse, empty space reads zero
    property p_rd_valid;
        I_REG_RD |=> O_REG_RVALID;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("no rvalid");
    property p_rd_once;
        !I_REG_RD |=> !O_REG_RVALID;
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("extra rvalid");
    property p_rd_none;
        I_REG_RD && !(I_REG_ADDR inside {8'h03, 8'h04}) |=>
            O_REG_RDATA == 8'h00;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped");
    // Pause enables can only follow a negotiated pause
    property p_tx_off;
        !I_AN_TX_PAUSE |=> !O_TX_FLOW_EN;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx pause");
    property p_rx_src;
        O_RX_FLOW_EN |-> $past(I_AN_RX_PAUSE);
    endproperty
    a_rx_src: assert property (p_rx_src) else $error("rx pause");
    // Verdict one cycle after each frame, nothing in between
    property p_done;
        I_FRAME_VALID |=> O_FRAME_DONE;
    endproperty
    a_done: assert property (p_done) else $error("no verdict");
    property p_done_src;
        O_FRAME_DONE |-> $past(I_FRAME_VALID);
    endproperty
    a_done_src: assert property (p_done_src) else $error("stray");
    property p_quiet;
        !O_FRAME_DONE |->
            !(O_FRAME_DROP || O_FRAME_VLAN_BLOCK || O_STORM_COUNT);
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray bits");
    c_drop: cover property (O_FRAME_DROP);
    c_vlan: cover property (O_FRAME_VLAN_BLOCK);
    c_storm: cover property (O_STORM_COUNT);
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps

bind sgcr_top sgcr_top_properties u_props
(
    .I_MCLK             (I_MCLK),
    .I_RST              (I_RST),
    .I_REG_RD           (I_REG_RD),
    .I_REG_ADDR         (I_REG_ADDR),
    .O_REG_RDATA        (O_REG_RDATA),
    .O_REG_RVALID       (O_REG_RVALID),
    .I_AN_TX_PAUSE      (I_AN_TX_PAUSE),
    .I_AN_RX_PAUSE      (I_AN_RX_PAUSE),
    .O_TX_FLOW_EN       (O_TX_FLOW_EN),
    .O_RX_FLOW_EN       (O_RX_FLOW_EN),
    .I_FRAME_VALID      (I_FRAME_VALID),
    .O_FRAME_DONE       (O_FRAME_DONE),
    .O_FRAME_DROP       (O_FRAME_DROP),
    .O_FRAME_VLAN_BLOCK (O_FRAME_VLAN_BLOCK),
    .O_STORM_COUNT      (O_STORM_COUNT)
);

module tb_top;
    logic [7:0] I_REG_ADDR = 8'h00;
    logic [7:0] I_REG_WDATA = 8'h00;
    logic       I_MCLK = 1'b0;
    logic       I_RST = 1'b1;
    logic       I_REG_WR = 1'b0;
    logic       I_REG_RD = 1'b0;
    logic       I_FLOW_CONTROL_STRAP_PIN = 1'b0;
    logic       I_BACKOFF_STRAP_PIN = 1'b0;
    logic       I_AN_TX_PAUSE = 1'b0;
    logic       I_AN_RX_PAUSE = 1'b0;
    logic       I_FRAME_VALID = 1'b0;
    sgcr_pkg::sgcr_frame_type I_FRAME = '0;
    logic [7:0] O_REG_RDATA;
    logic       O_REG_RVALID, O_TX_FLOW_EN, O_RX_FLOW_EN, O_AGE_TICK;
    logic       O_AGGR_BACKOFF_EN, O_FRAME_DONE, O_FRAME_DROP;
    logic       O_FRAME_VLAN_BLOCK, O_STORM_COUNT;
    int         errors = 0;
    int         comparisons = 0;
    // Lengths: type field, payload, whole frame
    localparam logic [47:0] OK64 = {16'h002E, 16'h002E, 16'h0040};
    localparam logic [47:0] BAD = {16'h002E, 16'h0028, 16'h0040};
    localparam logic [47:0] TOP = {16'h05DC, 16'h0028, 16'h0040};
    localparam logic [47:0] BIG = {16'h0800, 16'h0000, 16'h07D0};
    localparam logic [47:0] HUGE = {16'h0800, 16'h0000, 16'h0801};

    // Short aging periods keep the run brief
    sgcr_top
    #(
        .P_FAST_AGE_CYCLES   (36'h0_0000_0014),
        .P_NORMAL_AGE_CYCLES (36'h0_0000_0032)
    )
    dut
    (
        .I_MCLK                   (I_MCLK),
        .I_RST                    (I_RST),
        .I_REG_ADDR               (I_REG_ADDR),
        .I_REG_WR                 (I_REG_WR),
        .I_REG_WDATA              (I_REG_WDATA),
        .I_REG_RD                 (I_REG_RD),
        .O_REG_RDATA              (O_REG_RDATA),
        .O_REG_RVALID             (O_REG_RVALID),
        .I_FLOW_CONTROL_STRAP_PIN (I_FLOW_CONTROL_STRAP_PIN),
        .I_BACKOFF_STRAP_PIN      (I_BACKOFF_STRAP_PIN),
        .I_AN_TX_PAUSE            (I_AN_TX_PAUSE),
        .I_AN_RX_PAUSE            (I_AN_RX_PAUSE),
        .O_TX_FLOW_EN             (O_TX_FLOW_EN),
        .O_RX_FLOW_EN             (O_RX_FLOW_EN),
        .O_AGGR_BACKOFF_EN        (O_AGGR_BACKOFF_EN),
        .O_AGE_TICK               (O_AGE_TICK),
        .I_FRAME_VALID            (I_FRAME_VALID),
        .I_FRAME                  (I_FRAME),
        .O_FRAME_DONE             (O_FRAME_DONE),
        .O_FRAME_DROP             (O_FRAME_DROP),
        .O_FRAME_VLAN_BLOCK       (O_FRAME_VLAN_BLOCK),
        .O_STORM_COUNT            (O_STORM_COUNT)
    );

    always #5 I_MCLK = ~I_MCLK;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Straps steady through reset, then flipped to show they are ignored
    task automatic strap(input logic fc, input logic bo);
        @(posedge I_MCLK);
        {I_RST, I_AN_TX_PAUSE, I_AN_RX_PAUSE} <= 3'b100;
        {I_FLOW_CONTROL_STRAP_PIN, I_BACKOFF_STRAP_PIN} <= {fc, bo};
        repeat (6) @(posedge I_MCLK);
        I_RST <= 1'b0;
        @(posedge I_MCLK);
        {I_AN_TX_PAUSE, I_AN_RX_PAUSE} <= 2'b11;
        {I_FLOW_CONTROL_STRAP_PIN, I_BACKOFF_STRAP_PIN} <= {!fc, !bo};
    endtask

    // One strobe cycle; for a read, d is the expected data
    task automatic bus(input logic       w,
                       input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge I_MCLK);
        {I_REG_WR, I_REG_RD, I_REG_ADDR, I_REG_WDATA} <= {w, !w, a, d};
        @(posedge I_MCLK);
        {I_REG_WR, I_REG_RD} <= 2'b00;
        #1;
        if (!w)
            chk({O_REG_RVALID, O_REG_RDATA}, {1'b1, d});
    endtask

    task automatic outs(input logic [2:0] exp);
        repeat (2) @(posedge I_MCLK);
        #1;
        chk({O_TX_FLOW_EN, O_RX_FLOW_EN, O_AGGR_BACKOFF_EN}, exp);
    endtask

    task automatic frm(input logic [47:0] l, input logic [4:0] f,
                       input logic [2:0] exp);
        @(posedge I_MCLK);
        {I_FRAME_VALID, I_FRAME} <= {1'b1, l, f};
        @(posedge I_MCLK);
        I_FRAME_VALID <= 1'b0;
        #1;
        chk({O_FRAME_DONE, O_FRAME_DROP, O_FRAME_VLAN_BLOCK, O_STORM_COUNT},
            {1'b1, exp});
    endtask

    // Last gap between ticks in 130 cycles; zero when none come
    task automatic age(input logic [15:0] exp);
        int n;
        int last;
        int gap;
        last = 0;
        gap = 0;
        for (n = 1; n <= 130; n++)
        begin
            @(posedge I_MCLK);
            #1;
            if (O_AGE_TICK === 1'b1)
            begin
                gap = n - last;
                last = n;
            end
        end
        chk(16'(gap), exp);
    endtask

    initial
    begin
        strap(1'b1, 1'b1);
        bus(1'b0, 8'h03, 8'h35);
        bus(1'b0, 8'h04, 8'hC0);
        outs(3'b001);
        strap(1'b0, 1'b0);
        bus(1'b0, 8'h03, 8'h04);
        outs(3'b110);
        bus(1'b1, 8'h03, 8'h25);
        outs(3'b011);
        bus(1'b1, 8'h03, 8'h14);
        outs(3'b100);
        bus(1'b1, 8'h04, 8'hFF);
        bus(1'b0, 8'h04, 8'hC0);
        bus(1'b1, 8'h04, 8'h3F);
        bus(1'b0, 8'h04, 8'h00);
        bus(1'b0, 8'h05, 8'h00);
        frm(OK64, 5'b01100, 3'b000);
        frm(OK64, 5'b00100, 3'b010);
        frm(OK64, 5'b00001, 3'b001);
        frm(OK64, 5'b10000, 3'b100);
        frm(BIG, 5'b00010, 3'b101);
        bus(1'b1, 8'h04, 8'hC0);
        frm(OK64, 5'b01100, 3'b010);
        frm(OK64, 5'b00001, 3'b000);
        bus(1'b1, 8'h03, 8'hC4);
        frm(OK64, 5'b10000, 3'b000);
        bus(1'b1, 8'h03, 8'h44);
        frm(BIG, 5'b00000, 3'b000);
        frm(HUGE, 5'b00000, 3'b100);
        bus(1'b1, 8'h03, 8'h0C);
        frm(BAD, 5'b00000, 3'b100);
        frm(TOP, 5'b00000, 3'b000);
        frm(OK64, 5'b00000, 3'b000);
        bus(1'b1, 8'h03, 8'h04);
        frm(BAD, 5'b00000, 3'b000);
        age(16'd50);
        bus(1'b1, 8'h03, 8'h06);
        age(16'd20);
        bus(1'b1, 8'h03, 8'h02);
        age(16'd0);
        final_report();
    end

    // Whole run needs about 480 cycles; allow about thirty times that
    initial
    begin
        #150000;
        errors++;
        final_report();
    end
endmodule
